// [verilog/dacb_pkg.sv]
package dacb_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] STREAM_IO_CONFIG_ADDR     = 32'h8020_0384;
	localparam logic [31:0] ANALOG_INPUT_CONTROL_ADDR = 32'h8020_03A4;
	localparam logic [31:0] CONVERTER_CONTROL_ADDR    = 32'h8020_03A8;
	localparam logic [31:0] DECIMATOR_CONTROL_ADDR    = 32'h8020_03AC;
	localparam logic [31:0] DECIMATOR_STATUS_ADDR     = 32'h8020_03B0;
	localparam logic [31:0] SAMPLE_LEFT24_ADDR        = 32'h8020_03B4;
	localparam logic [31:0] SAMPLE_RIGHT24_ADDR       = 32'h8020_03B8;
	localparam logic [31:0] SAMPLE_PAIR16_ADDR        = 32'h8020_03BC;
	localparam logic [31:0] SAMPLE_FIFO_STATUS_ADDR   = 32'h8020_03C0;

	// ----------------------------------------------------------------
	// reset values and implemented-bit masks
	// ----------------------------------------------------------------
	localparam logic [31:0] STREAM_IO_RESET = 32'h0000_0180;
	localparam logic [31:0] STREAM_IO_MASK  = 32'h0000_00FF;
	localparam logic [31:0] AIN_MASK        = 32'h0007_1FFF;
	localparam logic [31:0] CONV_MASK       = 32'h0000_00FF;
	localparam logic [31:0] DEC_MASK        = 32'h007F_FFFF;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SIO_OE_BIT     = 7;
	localparam int AIN_RIGHT_DIFF_STAGE_POWERDOWN     = 0;
	localparam int AIN_LEFT_DIFF_STAGE_POWERDOWN     = 1;
	localparam int AIN_RIGHT_DIGITAL_GAIN_LSB  = 3;
	localparam int AIN_RAMP_PD    = 7;
	localparam int AIN_LGAIN_LSB  = 8;
	localparam int AIN_LAMP_PD    = 12;
	localparam int CONV_RDITHER   = 1;
	localparam int CONV_RPD       = 3;
	localparam int CONV_LDITHER   = 5;
	localparam int CONV_LPD       = 7;
	localparam int DEC_RIGHT_DIGITAL_GAIN_LSB  = 0;
	localparam int DEC_LGAIN_LSB  = 8;
	localparam int DEC_INV        = 17;
	localparam int DEC_MUTE       = 18;
	localparam int DEC_ENODC      = 19;
	localparam int DEC_ENIDC      = 20;
	localparam int FIFO_LOST_BIT  = 16;

	// ----------------------------------------------------------------
	// conversion constants
	// ----------------------------------------------------------------
	localparam int                 OSR           = 128;
	localparam int                 OVF_HOLD      = 512;
	localparam int                 DC_SHIFT      = 8;
	localparam logic [3:0]         AMP_GAIN_MAX  = 4'h8;
	localparam logic signed [7:0]  DIG_GAIN_MAX  = 8'sh30;
	localparam logic [7:0]         DIG_GAIN_MUTE = 8'h80;
	localparam logic [7:0]         GAIN_IDX_OFS  = 8'h84;
	localparam logic signed [23:0] OVF_THRESH    = 24'sh70_0000;
	localparam logic [14:0] GAIN_MANT [12] = '{15'h4000, 15'h43CE, 15'h47D6, 15'h4C1C,
		15'h50A3, 15'h556E, 15'h5A82, 15'h5FE4, 15'h6598, 15'h6BA2, 15'h7209, 15'h78D1};

	typedef struct packed {
		logic [23:0] left;
		logic [23:0] right;
	} dacb_pair_t;

	function automatic logic signed [23:0] dacb_sat24(input logic signed [55:0] v);
		if (v > 56'sh7F_FFFF)
			return 24'sh7F_FFFF;
		else if (v < -56'sh80_0000)
			return -24'sh80_0000;
		else
			return v[23:0];
	endfunction

endpackage

// [verilog/dacb_top.sv]
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module dacb_top #(
	parameter int BIT_DIV    = 8,
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic [1:0]           modBit,
	output logic                      modClkEn,
	output logic                      sampleStrobe,
	output logic                      audioInputOutputEnable,
	output logic                      rightDiffStagePowerdown,
	output logic                      leftDiffStagePowerdown,
	output logic                      rightAmpPowerdown,
	output logic                      leftAmpPowerdown,
	output logic      [3:0]           rightAmpGain,
	output logic      [3:0]           leftAmpGain,
	output logic      [1:0]           converterPowerdown,
	output logic      [1:0]           converterDither,
	output dacb_pkg::dacb_pair_t      samplePair,
	output logic                      dmaReq
);
	import dacb_pkg::*;

	localparam int PTR_W = $clog2(FIFO_DEPTH);

	if (BIT_DIV < 1 || FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
		$error("dacb_top: BIT_DIV >= 1 and power-of-two FIFO_DEPTH >= 2 required");
	end

	// ----------------------------------------------------------------
	// rate divider
	// ----------------------------------------------------------------
	logic [15:0] bitDivQ, bitDivD;
	logic [6:0]  bitCntQ, bitCntD;
	logic        bitTick, sampleTick;

	always_comb begin
		bitTick    = (bitDivQ == 16'(BIT_DIV - 1));
		sampleTick = bitTick && (bitCntQ == 7'(OSR - 1));
		bitDivD    = bitTick ? 16'h0000 : bitDivQ + 16'h0001;
		bitCntD    = bitTick ? bitCntQ + 7'h01 : bitCntQ;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bitDivQ <= 16'h0000;
			bitCntQ <= 7'h00;
		end else begin
			bitDivQ <= bitDivD;
			bitCntQ <= bitCntD;
		end
	end

	assign modClkEn     = bitTick;
	assign sampleStrobe = sampleTick;

	// ----------------------------------------------------------------
	// bus slave and register file
	// ----------------------------------------------------------------
	logic        accept, wrPendQ, wrPendD, pop, push, fifoFull, fifoEmpty;
	logic [31:0] wrAddrQ, wrAddrD, rdataQ, rdataD;
	logic [7:0]  sioQ, sioD;
	logic [31:0] ainQ, ainD, convQ, convD, decQ, decD;
	logic [31:0] ainAppQ, ainAppD, convAppQ, convAppD, decAppQ, decAppD;
	logic        lostQ, lostD, ovfFlagQ, ovfFlagD;
	logic [9:0]  ovfCntQ, ovfCntD;
	logic [1:0]  chanOvf;
	logic        muted;
	logic [PTR_W:0] wrPtrQ, wrPtrD, rdPtrQ, rdPtrD, fifoCnt;
	dacb_pair_t  fifoMem [FIFO_DEPTH];
	dacb_pair_t  head;
	logic signed [23:0] chanOut [2];
	logic        sampleValidQ;

	assign accept = hsel && htrans[1] && hready;
	assign muted  = decAppQ[DEC_MUTE] || (decAppQ[15:8] == DIG_GAIN_MUTE
		&& decAppQ[7:0] == DIG_GAIN_MUTE);
	assign head   = fifoMem[rdPtrQ[PTR_W-1:0]];

	always_comb begin
		wrPendD = accept && hwrite;
		wrAddrD = accept ? haddr : wrAddrQ;
		pop     = accept && !hwrite && !fifoEmpty
			&& (haddr == SAMPLE_RIGHT24_ADDR || haddr == SAMPLE_PAIR16_ADDR);
		rdataD  = rdataQ;
		if (accept && !hwrite) begin
			case (haddr)
				STREAM_IO_CONFIG_ADDR:     rdataD = (STREAM_IO_RESET & ~STREAM_IO_MASK)
					| {24'h000000, sioQ};
				ANALOG_INPUT_CONTROL_ADDR: rdataD = ainQ;
				CONVERTER_CONTROL_ADDR:    rdataD = convQ;
				DECIMATOR_CONTROL_ADDR:    rdataD = decQ;
				DECIMATOR_STATUS_ADDR:     rdataD = {30'h00000000, ovfFlagQ, muted};
				SAMPLE_LEFT24_ADDR:        rdataD = fifoEmpty ? 32'h00000000
					: {{8{head.left[23]}}, head.left};
				SAMPLE_RIGHT24_ADDR:       rdataD = fifoEmpty ? 32'h00000000
					: {{8{head.right[23]}}, head.right};
				SAMPLE_PAIR16_ADDR:        rdataD = fifoEmpty ? 32'h00000000
					: {head.left[23:8], head.right[23:8]};
				SAMPLE_FIFO_STATUS_ADDR:   rdataD = {15'h0000, lostQ, 16'(fifoCnt)};
				default:                   rdataD = 32'h00000000;
			endcase
		end
		sioD  = sioQ;
		ainD  = ainQ;
		convD = convQ;
		decD  = decQ;
		lostD = lostQ;
		if (wrPendQ) begin
			case (wrAddrQ)
				STREAM_IO_CONFIG_ADDR:     sioD  = hwdata[7:0];
				ANALOG_INPUT_CONTROL_ADDR: ainD  = hwdata & AIN_MASK;
				CONVERTER_CONTROL_ADDR:    convD = hwdata & CONV_MASK;
				DECIMATOR_CONTROL_ADDR:    decD  = hwdata & DEC_MASK;
				SAMPLE_FIFO_STATUS_ADDR:   lostD = lostQ && !hwdata[FIFO_LOST_BIT];
				default:                   ; // status is read-only
			endcase
		end
		// a dropped sample in the clearing cycle keeps the flag set
		if (push && fifoFull)
			lostD = 1'b1;
		// the analog side sees ain and converter changes only at a sample boundary; the output enable follows sioQ at once
		ainAppD  = sampleTick ? ainQ : ainAppQ;
		convAppD = sampleTick ? convQ : convAppQ;
		decAppD  = sampleTick ? decQ : decAppQ;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPendQ  <= 1'b0;
			wrAddrQ  <= 32'h00000000;
			rdataQ   <= 32'h00000000;
			sioQ     <= STREAM_IO_RESET[7:0];
			ainQ     <= CTRL_RESET;
			convQ    <= CTRL_RESET;
			decQ     <= CTRL_RESET;
			ainAppQ  <= CTRL_RESET;
			convAppQ <= CTRL_RESET;
			decAppQ  <= CTRL_RESET;
			lostQ    <= 1'b0;
		end else begin
			wrPendQ  <= wrPendD;
			wrAddrQ  <= wrAddrD;
			rdataQ   <= rdataD;
			sioQ     <= sioD;
			ainQ     <= ainD;
			convQ    <= convD;
			decQ     <= decD;
			ainAppQ  <= ainAppD;
			convAppQ <= convAppD;
			decAppQ  <= decAppD;
			lostQ    <= lostD;
		end
	end

	assign hrdata    = rdataQ;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ----------------------------------------------------------------
	// analog front-end controls
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rightAmpGain <= 4'h0;
			leftAmpGain  <= 4'h0;
		end else if (sampleTick) begin
			rightAmpGain <= ainQ[AIN_RIGHT_DIGITAL_GAIN_LSB+3] ? AMP_GAIN_MAX : ainQ[AIN_RIGHT_DIGITAL_GAIN_LSB+:4];
			leftAmpGain  <= ainQ[AIN_LGAIN_LSB+3] ? AMP_GAIN_MAX : ainQ[AIN_LGAIN_LSB+:4];
		end
	end

	assign audioInputOutputEnable  = sioQ[SIO_OE_BIT];
	assign rightDiffStagePowerdown = ainAppQ[AIN_RIGHT_DIFF_STAGE_POWERDOWN];
	assign leftDiffStagePowerdown  = ainAppQ[AIN_LEFT_DIFF_STAGE_POWERDOWN];
	assign rightAmpPowerdown       = ainAppQ[AIN_RAMP_PD];
	assign leftAmpPowerdown        = ainAppQ[AIN_LAMP_PD];
	assign converterPowerdown      = {convAppQ[CONV_LPD], convAppQ[CONV_RPD]};
	assign converterDither         = {convAppQ[CONV_LDITHER], convAppQ[CONV_RDITHER]};

	// ----------------------------------------------------------------
	// decimators: index 0 right, 1 left
	// ----------------------------------------------------------------
	for (genvar c = 0; c < 2; c++) begin : g_dec
		localparam int GL = (c == 0) ? DEC_RIGHT_DIGITAL_GAIN_LSB : DEC_LGAIN_LSB;
		localparam int PD = (c == 0) ? CONV_RPD : CONV_LPD;
		logic [7:0]         onesQ, onesD;
		logic signed [23:0] avgInQ, avgInD, avgOutQ, avgOutD, outQ, outD;
		logic [8:0]         total;
		logic signed [23:0] x, xi, gOut, y;
		logic signed [24:0] dIn, dOut;
		logic signed [7:0]  g, gc;
		logic [7:0]         idx;
		logic [3:0]         oct, frac;
		logic signed [39:0] prod;

		always_comb begin
			total = 9'(onesQ) + 9'(modBit[c]);
			x     = convAppQ[PD] ? 24'sh000000 : (24'($signed({1'b0, total})) - 24'sh000040) <<< 16;
			dIn   = 25'(x) - 25'(avgInQ);
			xi    = decAppQ[DEC_ENIDC] ? dacb_sat24(56'(dIn)) : x;
			if (decAppQ[DEC_INV])
				xi = dacb_sat24(-56'(xi));
			g     = $signed(decAppQ[GL+:8]);
			gc    = (g > DIG_GAIN_MAX) ? DIG_GAIN_MAX : g;
			idx   = 8'(gc) + GAIN_IDX_OFS;
			oct   = 4'(idx / 8'h0C);
			frac  = 4'(idx % 8'h0C);
			prod  = 40'(xi) * 40'($signed({1'b0, GAIN_MANT[frac]}));
			gOut  = dacb_sat24((56'(prod) <<< oct) >>> 25);
			if (g == $signed(DIG_GAIN_MUTE) || decAppQ[DEC_MUTE])
				gOut = 24'sh000000;
			dOut  = 25'(gOut) - 25'(avgOutQ);
			y     = decAppQ[DEC_ENODC] ? dacb_sat24(56'(dOut)) : gOut;
			onesD   = bitTick ? total[7:0] : onesQ;
			avgInD  = avgInQ;
			avgOutD = avgOutQ;
			outD    = outQ;
			if (sampleTick) begin
				onesD   = 8'h00;
				outD    = y;
				avgInD  = 24'(avgInQ + 24'(dIn >>> DC_SHIFT));
				avgOutD = 24'(avgOutQ + 24'(dOut >>> DC_SHIFT));
			end
			chanOvf[c] = sampleTick && (y >= OVF_THRESH || y <= -OVF_THRESH);
		end

		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				onesQ   <= 8'h00;
				avgInQ  <= 24'sh000000;
				avgOutQ <= 24'sh000000;
				outQ    <= 24'sh000000;
			end else begin
				onesQ   <= onesD;
				avgInQ  <= avgInD;
				avgOutQ <= avgOutD;
				outQ    <= outD;
			end
		end
		assign chanOut[c] = outQ;
	end

	// ----------------------------------------------------------------
	// overflow hold and sample FIFO
	// ----------------------------------------------------------------
	assign push      = sampleValidQ;
	assign fifoCnt   = wrPtrQ - rdPtrQ;
	assign fifoFull  = (fifoCnt == (PTR_W+1)'(FIFO_DEPTH));
	assign fifoEmpty = (fifoCnt == '0);
	assign dmaReq    = !fifoEmpty;

	always_comb begin
		ovfFlagD = ovfFlagQ;
		ovfCntD  = ovfCntQ;
		if (sampleTick) begin
			if (|chanOvf) begin
				ovfFlagD = 1'b1;
				ovfCntD  = 10'h000;
			end else if (ovfFlagQ) begin
				ovfFlagD = (ovfCntQ != 10'(OVF_HOLD - 1));
				ovfCntD  = ovfFlagD ? ovfCntQ + 10'h001 : 10'h000;
			end
		end
		wrPtrD = (push && !fifoFull) ? wrPtrQ + 1'b1 : wrPtrQ;
		rdPtrD = pop ? rdPtrQ + 1'b1 : rdPtrQ;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ovfFlagQ     <= 1'b0;
			ovfCntQ      <= 10'h000;
			wrPtrQ       <= '0;
			rdPtrQ       <= '0;
			sampleValidQ <= 1'b0;
			samplePair   <= '0;
		end else begin
			ovfFlagQ     <= ovfFlagD;
			ovfCntQ      <= ovfCntD;
			wrPtrQ       <= wrPtrD;
			rdPtrQ       <= rdPtrD;
			sampleValidQ <= sampleTick;
			if (sampleValidQ)
				samplePair <= {chanOut[1], chanOut[0]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push && !fifoFull)
			fifoMem[wrPtrQ[PTR_W-1:0]] <= {chanOut[1], chanOut[0]};
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	chk_lockstep_outputs: assert property (
		!$past(sampleTick) |-> $stable(chanOut[0]) && $stable(chanOut[1]))
		else $error("channel output moved outside a sample tick");
	chk_tick_spacing: assert property (sampleTick |=> !sampleTick [*8])
		else $error("sample ticks too close");
	chk_word_per_period: assert property (
		sampleTick |=> sampleValidQ ##1 !sampleValidQ)
		else $error("sample word not produced once per period");
	chk_fifo_bounded: assert property (fifoCnt <= (PTR_W+1)'(FIFO_DEPTH)
		&& dmaReq == (fifoCnt != '0))
		else $error("fifo count or dma request wrong");
	chk_oe_write: assert property (
		(wrPendQ && wrAddrQ == STREAM_IO_CONFIG_ADDR)
		|=> audioInputOutputEnable == $past(hwdata[SIO_OE_BIT]))
		else $error("output enable did not follow write");
	chk_amp_gain_clamp: assert property (
		(sampleTick && ainQ[AIN_RIGHT_DIGITAL_GAIN_LSB+3]) |=> rightAmpGain == AMP_GAIN_MAX)
		else $error("right amp gain not clamped");
	chk_status_reads: assert property (
		(accept && !hwrite && haddr == DECIMATOR_STATUS_ADDR)
		|=> hrdata[31:2] == 30'h00000000 && hrdata[1] == $past(ovfFlagQ))
		else $error("status read wrong");
	chk_ovf_hold: assert property ($fell(ovfFlagQ) |->
		$past(ovfCntQ) == 10'(OVF_HOLD - 1) && $past(sampleTick))
		else $error("overflow flag released early");
	chk_mute_zero: assert property (
		(sampleTick && muted && !decAppQ[DEC_ENODC])
		|=> chanOut[0] == 24'sh000000 && chanOut[1] == 24'sh000000)
		else $error("muted channel not zero");
	chk_apply_on_tick: assert property (!$past(sampleTick) |->
		$stable(ainAppQ) && $stable(decAppQ))
		else $error("control applied between ticks");

	cov_overflow: cover property (sampleTick && |chanOvf);
	cov_fifo_full: cover property (fifoFull && push);
	cov_pair_pop: cover property (pop && haddr == SAMPLE_PAIR16_ADDR);

endmodule

// [dv/dacb_src.sv]
`timescale 1ns/1ps
module dacb_src (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       modClkEn,
	input  wire logic [7:0] levelRight,
	input  wire logic [7:0] levelLeft,
	output logic      [1:0] modBit
);
	// ----------------------------------------------------------------
	// bit pattern of period 128, so any aligned or unaligned window
	// of 128 bits holds exactly level ones for levels up to 128, and 128 ones for any higher level
	// ----------------------------------------------------------------
	logic [6:0] phase_q;
	logic [6:0] phase_d;

	always_comb begin
		phase_d = modClkEn ? phase_q + 7'h01 : phase_q;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			phase_q <= 7'h00;
		else
			phase_q <= phase_d;
	end

	assign modBit = {8'(phase_q) < levelLeft, 8'(phase_q) < levelRight};
endmodule

// [dv/dacb_top_tb.sv]
`timescale 1ns/1ps
module dacb_top_tb;
	import dacb_pkg::*;
	localparam int BD    = 2;
	localparam int DEPTH = 8;
	logic        ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, modClkEn, sampleStrobe, dmaReq;
	logic        aoe, rdPd, ldPd, raPd, laPd;
	logic [1:0]  htrans, modBit, cvPd, cvDi;
	logic [2:0]  hsize;
	logic [3:0]  raGain, laGain;
	logic [7:0]  levelL, levelR;
	logic [31:0] haddr, hwdata, hrdata, q, v, eL, eR;
	dacb_pair_t  samplePair;
	int          miscompares, checks, cycles, n, m;
	logic [31:0] zeroAddr [4] = '{ANALOG_INPUT_CONTROL_ADDR, CONVERTER_CONTROL_ADDR,
		DECIMATOR_CONTROL_ADDR, DECIMATOR_STATUS_ADDR};

	dacb_top #(.BIT_DIV(BD), .FIFO_DEPTH(DEPTH)) dacb_top_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .modBit(modBit), .modClkEn(modClkEn), .sampleStrobe(sampleStrobe),
		.audioInputOutputEnable(aoe), .rightDiffStagePowerdown(rdPd),
		.leftDiffStagePowerdown(ldPd), .rightAmpPowerdown(raPd), .leftAmpPowerdown(laPd),
		.rightAmpGain(raGain), .leftAmpGain(laGain), .converterPowerdown(cvPd),
		.converterDither(cvDi), .samplePair(samplePair), .dmaReq(dmaReq));
	dacb_src dacb_src_i (.ref_clk(ref_clk), .rst_n(rst_n), .modClkEn(modClkEn),
		.levelRight(levelR), .levelLeft(levelL), .modBit(modBit));

	// ----------------------------------------------------------------
	// checking and bus tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD reg t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD pin t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		q = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask

	task automatic rd(input logic [31:0] a);
		bus(a, 1'b0, 32'h0000_0000);
	endtask

	// waits past the tick so applied controls and the new pair have landed
	task automatic tick(input int k);
		repeat (k) begin
			@(negedge ref_clk);
			while (sampleStrobe !== 1'b1) @(negedge ref_clk);
			repeat (3) @(posedge ref_clk);
		end
	endtask

	task automatic drain();
		for (int k = 0; k < 2 * DEPTH && dmaReq === 1'b1; k++)
			rd(SAMPLE_PAIR16_ADDR);
	endtask

	function automatic logic [31:0] expSamp(input logic [7:0] lvl);
		return (32'(lvl) - 32'h0000_0040) << 16;
	endfunction

	function automatic logic [31:0] sx(input logic [23:0] s);
		return {{8{s[23]}}, s};
	endfunction

	// ----------------------------------------------------------------
	// clock, timeout and main sequence
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 90000) begin
			miscompares++;
			report_and_stop();
		end
	end

	initial begin
		{rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		levelL = 8'h40;
		levelR = 8'h40;
		void'($urandom(32'h8F6C_1F8B));
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(STREAM_IO_CONFIG_ADDR);
		cmp_reg(q, STREAM_IO_RESET);
		cmp_pin(32'(aoe), 32'h0000_0001);
		foreach (zeroAddr[i]) begin
			rd(zeroAddr[i]);
			cmp_reg(q, CTRL_RESET);
		end
		wr(STREAM_IO_CONFIG_ADDR, 32'h0000_007F);
		@(negedge ref_clk);
		cmp_pin(32'(aoe), 32'h0000_0000);
		rd(STREAM_IO_CONFIG_ADDR);
		cmp_reg(q, 32'h0000_017F);
		wr(STREAM_IO_CONFIG_ADDR, 32'h0000_00FF);
		wr(DECIMATOR_STATUS_ADDR, 32'h0000_0003);
		rd(DECIMATOR_STATUS_ADDR);
		cmp_reg(q, 32'h0000_0000);
		rd(32'h8020_0390);
		cmp_reg(q, 32'h0000_0000);
		cmp_pin(32'(hresp), 32'h0000_0000);
		// one tick spans 128 bit slots of BD clocks each
		@(negedge ref_clk);
		while (sampleStrobe !== 1'b1) @(negedge ref_clk);
		n = 0;
		m = 0;
		do begin
			@(negedge ref_clk);
			n++;
			m += int'(modClkEn);
		end while (sampleStrobe !== 1'b1 && n < 1000);
		@(posedge ref_clk);
		cmp_pin(32'(m), 32'd128);
		cmp_pin(32'(n), 32'(128 * BD));
		for (int c = 0; c < 16; c++) begin
			v = 32'h0006_0004 | (32'(c) << 3) | (32'(15 - c) << 8) | ($urandom & 32'h0000_1083);
			wr(ANALOG_INPUT_CONTROL_ADDR, v);
			rd(ANALOG_INPUT_CONTROL_ADDR);
			cmp_reg(q, v);
			tick(1);
			cmp_pin({rdPd, ldPd, raPd, laPd, raGain, laGain}, {v[0], v[1], v[7], v[12],
				(c > 8) ? 4'h8 : 4'(c), (c < 7) ? 4'h8 : 4'(15 - c)});
		end
		for (int k = 0; k < 4; k++) begin
			v = 32'h0000_0011 | ($urandom & 32'h0000_00AA);
			wr(CONVERTER_CONTROL_ADDR, v);
			rd(CONVERTER_CONTROL_ADDR);
			cmp_reg(q, v);
			tick(1);
			cmp_pin(32'({cvPd, cvDi}), 32'({v[7], v[3], v[5], v[1]}));
		end
		wr(CONVERTER_CONTROL_ADDR, 32'h0000_0011);
		levelL <= 8'(70 + $urandom_range(50));
		levelR <= 8'(10 + $urandom_range(50));
		tick(4);
		eL = expSamp(levelL);
		eR = expSamp(levelR);
		cmp_pin(sx(samplePair.left), eL);
		cmp_pin(sx(samplePair.right), eR);
		drain();
		tick(DEPTH + 2);
		cmp_pin(32'(dmaReq), 32'h0000_0001);
		rd(SAMPLE_FIFO_STATUS_ADDR);
		cmp_reg(q, 32'h0001_0000 | 32'(DEPTH));
		rd(SAMPLE_LEFT24_ADDR);
		cmp_reg(q, eL);
		rd(SAMPLE_RIGHT24_ADDR);
		cmp_reg(q, eR);
		rd(SAMPLE_PAIR16_ADDR);
		cmp_reg(q, {eL[23:8], eR[23:8]});
		wr(SAMPLE_FIFO_STATUS_ADDR, 32'h0001_0000);
		rd(SAMPLE_FIFO_STATUS_ADDR);
		cmp_reg(q & 32'h0001_0000, 32'h0000_0000);
		drain();
		cmp_pin(32'(dmaReq), 32'h0000_0000);
		levelL <= 8'h80;
		levelR <= 8'h00;
		wr(DECIMATOR_CONTROL_ADDR, 32'h0000_4030);
		tick(3);
		cmp_pin(sx(samplePair.left), 32'h007F_FFFF);
		cmp_pin(sx(samplePair.right), 32'hFF80_0000);
		rd(DECIMATOR_STATUS_ADDR);
		cmp_reg(q, 32'h0000_0002);
		wr(DECIMATOR_CONTROL_ADDR, 32'h0000_8080);
		tick(3);
		cmp_pin(sx(samplePair.left), 32'h0000_0000);
		cmp_pin(sx(samplePair.right), 32'h0000_0000);
		rd(DECIMATOR_STATUS_ADDR);
		cmp_reg(q, 32'h0000_0003);
		// dc blockers pull a constant input towards zero; overflow must still hold
		levelL <= 8'h60;
		wr(DECIMATOR_CONTROL_ADDR, 32'h0018_0000);
		tick(200);
		cmp_pin(32'($signed(sx(samplePair.left)) < $signed(expSamp(8'h60))), 32'h1);
		rd(DECIMATOR_STATUS_ADDR);
		cmp_reg(q, 32'h0000_0002);
		// inversion with the right converter powered down, filters off
		wr(CONVERTER_CONTROL_ADDR, 32'h0000_0019);
		wr(DECIMATOR_CONTROL_ADDR, 32'h0002_0000);
		tick(3);
		cmp_pin(sx(samplePair.left), 32'h0000_0000 - expSamp(8'h60));
		cmp_pin(sx(samplePair.right), 32'h0000_0000);
		// mute by the control bit alone, gains left at zero
		wr(DECIMATOR_CONTROL_ADDR, 32'h0004_0000);
		tick(3);
		cmp_pin(sx(samplePair.left), 32'h0000_0000);
		rd(DECIMATOR_STATUS_ADDR);
		cmp_reg(q, 32'h0000_0003);
		report_and_stop();
	end
endmodule
